/* File: rif_pkg.sv */
// Package for the RTC interrupt flag and control block.
// Assumes a single 100 MHz clock; register access over a simple byte port.
package rif_pkg;
  localparam logic [7:0] ADDR_FLAGS = 8'h00;
  localparam logic [7:0] ADDR_ENABLES = 8'h01;
  localparam logic [7:0] ADDR_RESET = 8'h02;
  localparam logic [7:0] ADDR_CONFIG1 = 8'h03;
  localparam logic [7:0] ADDR_CONFIG2 = 8'h04;
  localparam int BIT_SOURCE = 7;
  localparam int BIT_OSC = 6;
  localparam int BIT_SUPPLY_FAIL = 5;
  localparam int BIT_BATLOW = 4;
  localparam int BIT_DIN = 3;
  localparam int BIT_TIMER = 2;
  localparam int BIT_ALARM2 = 1;
  localparam int BIT_ALARM1 = 0;
  localparam int BIT_SOFT_RESET = 0;
  localparam int BIT_POLARITY = 3;
  localparam int BIT_OSC_ON = 0;
  localparam int BIT_CLKOUT_SEL = 2;
  localparam int AC_LO = 4;
  localparam logic [7:0] RST_ENABLES = 8'h00;
  localparam logic [7:0] RST_CONFIG1 = 8'h03;
  localparam logic [7:0] RST_CONFIG2 = 8'h03;
  localparam logic [7:0] MASK_ENABLES = 8'h7f;
  localparam logic [7:0] MASK_CONFIG1 = 8'h3b;
  localparam logic [7:0] MASK_CONFIG2 = 8'h1f;
  localparam int CLK_HZ = 100_000_000;
  localparam int AC_SHORT_MS = 10;
  localparam int AC_MID_MS = 500;
  localparam int AC_LONG_MS = 5000;
  localparam int AC_SHORT_CYC = CLK_HZ / 1000 * AC_SHORT_MS;
  localparam int AC_MID_CYC = CLK_HZ / 1000 * AC_MID_MS;
  localparam int AC_LONG_CYC = CLK_HZ / 1000 * AC_LONG_MS;
  localparam int AC_CNT_W = 32;
  localparam int REG_COUNT = 5;
  localparam int REG_IDX_W = 3;

  typedef struct packed {
    logic source_on_backup;
    logic osc_stopped;
    logic main_supply_fail;
    logic battery_low;
    logic timer_expired;
    logic alarm2_match;
    logic alarm1_match;
    logic din;
  } rif_events_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } rif_bus_t;
endpackage : rif_pkg

/* File: rif_regfile.sv */
// Small register memory for the RTC interrupt block control registers.
// Read data come out of a register one cycle after the address.
`timescale 1ns/100ps
`default_nettype none
module rif_regfile
  import rif_pkg::*;
(
  input wire logic i_ref_clk,
  input wire logic i_rst_b,
  input wire logic i_clear,
  input wire logic i_we,
  input wire logic [REG_IDX_W-1:0] i_waddr,
  input wire logic [7:0] i_wdata,
  input wire logic [REG_IDX_W-1:0] i_raddr,
  output logic [7:0] o_rdata,
  output logic [7:0] o_enables,
  output logic [7:0] o_config1,
  output logic [7:0] o_config2
);
  typedef struct packed {
    logic [7:0] enables;
    logic [7:0] config1;
    logic [7:0] config2;
    logic [7:0] rdata;
  } rif_rf_state_t;

  rif_rf_state_t st;
  rif_rf_state_t next_st;

  always_comb begin
    next_st = st;
    if (i_we) begin
      case (i_waddr)
        ADDR_ENABLES[REG_IDX_W-1:0]: next_st.enables = i_wdata & MASK_ENABLES;
        ADDR_CONFIG1[REG_IDX_W-1:0]: next_st.config1 = i_wdata & MASK_CONFIG1;
        ADDR_CONFIG2[REG_IDX_W-1:0]: next_st.config2 = i_wdata & MASK_CONFIG2;
        default: next_st.rdata = st.rdata;
      endcase
    end
    case (i_raddr)
      ADDR_ENABLES[REG_IDX_W-1:0]: next_st.rdata = st.enables;
      ADDR_CONFIG1[REG_IDX_W-1:0]: next_st.rdata = st.config1;
      ADDR_CONFIG2[REG_IDX_W-1:0]: next_st.rdata = st.config2;
      default: next_st.rdata = 8'h00;
    endcase
    // Soft reset restores enables and config2, and loads config1 with the oscillator-on bit cleared
    if (i_clear) begin
      next_st.enables = RST_ENABLES;
      next_st.config1 = RST_CONFIG1 & ~(8'h01 << BIT_OSC_ON);
      next_st.config2 = RST_CONFIG2;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_b) begin
      st <= '{RST_ENABLES, RST_CONFIG1, RST_CONFIG2, 8'h00};
    end else begin
      st <= next_st;
    end
  end

  assign o_rdata = st.rdata;
  assign o_enables = st.enables;
  assign o_config1 = st.config1;
  assign o_config2 = st.config2;
endmodule : rif_regfile
`default_nettype wire

/* File: rif_top.sv */
// RTC interrupt flags, enables, soft reset and first configuration register.
// Assumes event inputs synchronous to i_ref_clk and a byte register port
// driven by the serial-bus front end; i_rd_done marks a completed read.
//
// Functional notes
// RULE1: Flag bit 7 shows supply source, 1 is backup; reads never clear it.
// RULE2: Flag bit 6 reads 1 while oscillator stopped; not cleared by reads.
// RULE3: Flag bit 5 sets on main-supply fail, holds until a completed read.
// RULE4: Battery-low flag bit 4 clears after a completed read.
// RULE5: Digital input flag bit 3 clears after a completed read.
// RULE6: Countdown flag bit 2 clears after a completed read.
// RULE7: Second alarm flag bit 1 clears after a completed read.
// RULE8: First alarm flag bit 0 clears after a completed read.
// RULE9: First alarm match sets flag; with enable it drives an interrupt pin.
// RULE10: Enable bit 6 set suppresses the oscillator stop flag.
// RULE11: Enable bits 5, 4 gate supply-fail and battery-low flags and pins.
// RULE12: Enable bits 3..0 gate input, timer, alarm2 and alarm1 flags.
// RULE13: Soft reset bit clears logic and registers, disables the oscillator.
// RULE14: Field 5:4 picks alarm1 auto-clear: read only, 10ms, 500ms, 5s.
// RULE15: Host avoids the 5s auto-clear when alarm1 fires every second.
// RULE16: Config bit 3 picks input edge: 0 falling, 1 rising.
// RULE17: Config bit 0 turns the crystal oscillator on or off.
// RULE18: With clock output selected, alarm1 interrupt moves to first pin.
// RULE19: Interrupt pins are active low while any routed enabled flag is set.
`timescale 1ns/100ps
`default_nettype none
module rif_top
  import rif_pkg::*;
(
  input wire logic i_ref_clk,
  input wire logic i_rst_b,
  input wire rif_bus_t i_bus,
  input wire logic i_rd_done,
  input wire rif_events_t i_events,
  output logic [7:0] o_rdata,
  output logic o_first_interrupt_pin_b,
  output logic o_second_interrupt_pin_b,
  output logic o_crystal_oscillator_on,
  output logic o_clock_output_select,
  output logic o_soft_reset_pulse
);
  typedef struct packed {
    logic [7:0] flags;
    logic soft_reset_bit;
    logic din_prev;
    logic [AC_CNT_W-1:0] ac_count;
    logic ac_running;
    logic flags_read;
    logic rd_flags_sel;
    logic rd_reset_sel;
    logic [7:0] rdata;
    logic irq_a_b;
    logic irq_b_b;
    logic osc_on;
    logic clk_sel;
    logic soft_pulse;
  } rif_state_t;

  rif_state_t st;
  rif_state_t next_st;
  logic [7:0] rf_rdata;
  logic [7:0] enables;
  logic [7:0] config1;
  logic [7:0] config2;
  logic soft_clear;
  logic rf_we;
  logic [REG_IDX_W-1:0] rf_waddr;
  logic [REG_IDX_W-1:0] rf_raddr;
  logic rf_addr_ok;

  function automatic logic is_addr(input logic [7:0] a, input logic [7:0] r);
    return a == r;
  endfunction : is_addr

  function automatic logic [AC_CNT_W-1:0] ac_limit(input logic [1:0] sel);
    case (sel)
      2'h1: return AC_CNT_W'(AC_SHORT_CYC);
      2'h2: return AC_CNT_W'(AC_MID_CYC);
      2'h3: return AC_CNT_W'(AC_LONG_CYC);
      default: return '0;
    endcase
  endfunction : ac_limit

  assign soft_clear = st.soft_reset_bit; // RULE13
  // Out-of-range addresses go to an unmapped slot so they never alias
  assign rf_addr_ok = (i_bus.addr[7:REG_IDX_W] == '0);
  assign rf_we = i_bus.wr && rf_addr_ok && !soft_clear;
  assign rf_waddr = i_bus.addr[REG_IDX_W-1:0];
  assign rf_raddr = rf_addr_ok ? i_bus.addr[REG_IDX_W-1:0]
                               : REG_IDX_W'(REG_COUNT);

  rif_regfile u_regs (
    .i_ref_clk(i_ref_clk),
    .i_rst_b(i_rst_b),
    .i_clear(soft_clear),
    .i_we(rf_we),
    .i_waddr(rf_waddr),
    .i_wdata(i_bus.wdata),
    .i_raddr(rf_raddr),
    .o_rdata(rf_rdata),
    .o_enables(enables),
    .o_config1(config1),
    .o_config2(config2)
  );

  always_comb begin
    logic din_edge;
    logic [7:0] set_v;
    logic [7:0] clr_v;
    logic a1_routed_a;
    din_edge = 1'b0;
    set_v = 8'h00;
    clr_v = 8'h00;
    a1_routed_a = 1'b0;
    next_st = st;
    next_st.soft_pulse = 1'b0;
    next_st.din_prev = i_events.din;
    // Edge select on the digital input
    if (config1[BIT_POLARITY]) begin // RULE16
      din_edge = i_events.din && !st.din_prev;
    end else begin
      din_edge = !i_events.din && st.din_prev;
    end
    set_v[BIT_SUPPLY_FAIL] = i_events.main_supply_fail
                             && enables[BIT_SUPPLY_FAIL]; // RULE3 RULE11
    set_v[BIT_BATLOW] = i_events.battery_low && enables[BIT_BATLOW]; // RULE11
    set_v[BIT_DIN] = din_edge && enables[BIT_DIN]; // RULE12
    set_v[BIT_TIMER] = i_events.timer_expired && enables[BIT_TIMER]; // RULE12
    set_v[BIT_ALARM2] = i_events.alarm2_match && enables[BIT_ALARM2]; // RULE12
    set_v[BIT_ALARM1] = i_events.alarm1_match && enables[BIT_ALARM1]; // RULE9
    // Sticky flags clear after a completed flag read; a new set wins
    if (st.flags_read && i_rd_done) begin
      clr_v = 8'h3f; // RULE4 RULE5 RULE6 RULE7 RULE8
    end
    if (st.ac_running && st.ac_count == 0) begin
      clr_v[BIT_ALARM1] = 1'b1; // RULE14
    end
    next_st.flags[5:0] = (st.flags[5:0] & ~clr_v[5:0]) | set_v[5:0];
    next_st.flags[BIT_SOURCE] = i_events.source_on_backup; // RULE1
    next_st.flags[BIT_OSC] = i_events.osc_stopped
                             && !enables[BIT_OSC]; // RULE2 RULE10
    // Alarm1 auto-clear timer, restarted on each assertion
    if (set_v[BIT_ALARM1] && config1[AC_LO+:2] != 2'h0) begin
      next_st.ac_running = 1'b1;
      next_st.ac_count = ac_limit(config1[AC_LO+:2]) - AC_CNT_W'(1); // RULE14
    end else if (!next_st.flags[BIT_ALARM1] || config1[AC_LO+:2] == 2'h0) begin
      next_st.ac_running = 1'b0;
      next_st.ac_count = '0;
    end else if (st.ac_running) begin
      next_st.ac_count = st.ac_count - AC_CNT_W'(1);
    end
    // Read tracking and read data
    if (i_bus.rd) begin
      next_st.flags_read = is_addr(i_bus.addr, ADDR_FLAGS);
      next_st.rd_flags_sel = is_addr(i_bus.addr, ADDR_FLAGS);
      next_st.rd_reset_sel = is_addr(i_bus.addr, ADDR_RESET);
    end else if (i_rd_done) begin
      next_st.flags_read = 1'b0;
    end
    // Flag and reset read data follow the last read address; register read data follow the current bus address
    if (st.rd_flags_sel) begin
      next_st.rdata = st.flags;
    end else if (st.rd_reset_sel) begin
      next_st.rdata = {7'h00, st.soft_reset_bit};
    end else begin
      next_st.rdata = rf_rdata;
    end
    // Soft reset bit: set by write, self-clears after one clearing cycle
    if (i_bus.wr && is_addr(i_bus.addr, ADDR_RESET)) begin
      next_st.soft_reset_bit = i_bus.wdata[BIT_SOFT_RESET]; // RULE13
      next_st.soft_pulse = i_bus.wdata[BIT_SOFT_RESET];
    end else if (st.soft_reset_bit) begin
      next_st.soft_reset_bit = 1'b0;
    end
    if (soft_clear) begin
      next_st.flags[5:0] = 6'h00; // RULE13
      next_st.ac_running = 1'b0;
      next_st.ac_count = '0;
    end
    next_st.osc_on = config1[BIT_OSC_ON] && !soft_clear; // RULE17 RULE13
    next_st.clk_sel = config2[BIT_CLKOUT_SEL];
    // Pin routing of enabled flags
    a1_routed_a = config2[BIT_CLKOUT_SEL]; // RULE18
    next_st.irq_a_b = !(|(st.flags[5:1] & enables[5:1])
                        || (a1_routed_a && st.flags[BIT_ALARM1]
                            && enables[BIT_ALARM1])); // RULE19 RULE9
    next_st.irq_b_b = !(!a1_routed_a && st.flags[BIT_ALARM1]
                        && enables[BIT_ALARM1]); // RULE19 RULE9
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_b) begin
      st <= '0;
      st.irq_a_b <= 1'b1;
      st.irq_b_b <= 1'b1;
      st.osc_on <= RST_CONFIG1[BIT_OSC_ON];
      st.flags <= 8'h40;
    end else begin
      st <= next_st;
    end
  end

  assign o_rdata = st.rdata;
  assign o_first_interrupt_pin_b = st.irq_a_b;
  assign o_second_interrupt_pin_b = st.irq_b_b;
  assign o_crystal_oscillator_on = st.osc_on;
  assign o_clock_output_select = st.clk_sel;
  assign o_soft_reset_pulse = st.soft_pulse;
endmodule : rif_top
`default_nettype wire

/* File: rif_host_model.sv */
// Host model: byte register port plus completed-read strobe.
// Assumes the bench calls its tasks; drives on the falling edge.
`timescale 1ns/100ps
`default_nettype none
module rif_host_model
  import rif_pkg::*;
(
  input wire logic i_ref_clk,
  input wire logic [7:0] i_rdata,
  output rif_bus_t o_bus,
  output logic o_rd_done
);
  initial o_bus = '0;
  initial o_rd_done = 1'b0;
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] v);
    @(negedge i_ref_clk);
    o_bus = '{1'b1, 1'b0, a, v};
    @(negedge i_ref_clk);
    o_bus.wr = 1'b0;
    o_bus.wdata = ~v;
  endtask : wr_reg
  // Address is held after a read: read data track the last address
  task automatic rd_reg(input logic [7:0] a, output logic [7:0] v,
      input logic ok);
    @(negedge i_ref_clk);
    o_bus.rd = 1'b1;
    o_bus.addr = a;
    @(negedge i_ref_clk);
    o_bus.rd = 1'b0;
    repeat (2) @(negedge i_ref_clk);
    v = i_rdata;
    o_rd_done = ok;
    @(negedge i_ref_clk);
    o_rd_done = 1'b0;
  endtask : rd_reg
endmodule : rif_host_model
`default_nettype wire

/* File: rif_top_props.sv */
// Port checks for the interrupt flag block.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/100ps
`default_nettype none
module rif_top_props
  import rif_pkg::*;
(
  input wire logic i_ref_clk,
  input wire logic i_rst_b,
  input wire rif_bus_t i_bus,
  input wire logic i_rd_done,
  input wire rif_events_t i_events,
  input wire logic [7:0] o_rdata,
  input wire logic o_first_interrupt_pin_b,
  input wire logic o_second_interrupt_pin_b,
  input wire logic o_crystal_oscillator_on,
  input wire logic o_clock_output_select,
  input wire logic o_soft_reset_pulse
);
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_b);
  property p_rst_vals;
    $rose(i_rst_b) |-> o_first_interrupt_pin_b && o_second_interrupt_pin_b
      && o_crystal_oscillator_on && !o_clock_output_select && o_rdata == 0;
  endproperty
  a_rst_vals: assert property (p_rst_vals) else $error("reset values");
  property p_pulse_one;
    o_soft_reset_pulse |=> !o_soft_reset_pulse;
  endproperty
  a_pulse_one: assert property (p_pulse_one) else $error("long pulse");
  property p_pulse_wr;
    i_bus.wr && i_bus.addr == ADDR_RESET && i_bus.wdata[0]
      && !o_soft_reset_pulse |-> ##[1:2] o_soft_reset_pulse;
  endproperty
  a_pulse_wr: assert property (p_pulse_wr) else $error("no pulse");
  property p_soft_reset_bit_osc;
    o_soft_reset_pulse |-> ##[0:2] !o_crystal_oscillator_on;
  endproperty
  a_soft_reset_bit_osc: assert property (p_soft_reset_bit_osc) else $error("osc kept");
  property p_osc_wr;
    i_bus.wr && i_bus.addr == ADDR_CONFIG1 && !o_soft_reset_pulse |->
      ##2 o_crystal_oscillator_on == $past(i_bus.wdata[0], 2);
  endproperty
  a_osc_wr: assert property (p_osc_wr) else $error("osc enable");
  property p_clk_wr;
    i_bus.wr && i_bus.addr == ADDR_CONFIG2 && !o_soft_reset_pulse |->
      ##2 o_clock_output_select == $past(i_bus.wdata[2], 2);
  endproperty
  a_clk_wr: assert property (p_clk_wr) else $error("clock select");
  property p_unmapped;
    i_bus.rd && i_bus.addr > 8'h04 ##1 !i_bus.rd |-> ##2 o_rdata == 8'h00;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read");
  property p_src;
    (i_bus.rd && i_bus.addr == ADDR_FLAGS && i_events.source_on_backup)
      ##1 i_events.source_on_backup [*3] |-> o_rdata[7];
  endproperty
  a_src: assert property (p_src) else $error("source bit");
endmodule : rif_top_props
bind rif_top rif_top_props i_props (.*);
`default_nettype wire

/* File: rif_top_tb.sv */
// Self-checking bench for the interrupt flag block.
// Assumes the host model and checker files are compiled first.
`timescale 1ns/100ps
`default_nettype none
module rif_top_tb;
  import rif_pkg::*;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  rif_bus_t bus;
  rif_events_t ev = '0;
  logic rd_done, pa_b, pb_b, osc_on, cs, pulse;
  logic [7:0] rdata, d, en;
  logic [5:0] f;
  int n_fail = 0;
  int checks = 0;
  always #5 clk = ~clk;
  rif_top i_dut (.i_ref_clk(clk), .i_rst_b(rst_b), .i_bus(bus),
    .i_rd_done(rd_done), .i_events(ev), .o_rdata(rdata),
    .o_first_interrupt_pin_b(pa_b), .o_second_interrupt_pin_b(pb_b),
    .o_crystal_oscillator_on(osc_on), .o_clock_output_select(cs),
    .o_soft_reset_pulse(pulse));
  rif_host_model i_host (.i_ref_clk(clk), .i_rdata(rdata), .o_bus(bus),
    .o_rd_done(rd_done));
  task automatic chk(input string nm, input logic [7:0] x,
      input logic [7:0] y);
    checks++;
    if (y !== x) begin
      n_fail++;
      $display("MISMATCH %s exp %h got %h", nm, x, y);
    end
  endtask : chk
  task automatic complete_run;
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : complete_run
  // Alarm1 leaves the second pin when clock output is selected
  function automatic logic [7:0] pins(input logic [5:0] fl, input logic s);
    return {6'h0, !(!s && fl[0]), !(fl[5:1] != 0 || (s && fl[0]))};
  endfunction : pins
  task automatic fire(input logic [5:0] v);
    @(negedge clk);
    ev[5:1] = {v[5], v[4], v[2], v[1], v[0]};
    @(negedge clk);
    ev[5:1] = '0;
    repeat (2) @(negedge clk);
  endtask : fire
  task automatic rdf(input logic [7:0] x);
    i_host.rd_reg(ADDR_FLAGS, d, 1'b1);
    chk("flags", x, d);
  endtask : rdf
  initial begin
    repeat (20000) @(posedge clk);
    n_fail++;
    complete_run();
  end
  initial begin
    void'($urandom(91));
    repeat (12) @(posedge clk);
    @(negedge clk);
    rst_b = 1'b1;
    i_host.rd_reg(ADDR_ENABLES, d, 1'b0);
    chk("enables", 8'h00, d);
    i_host.rd_reg(ADDR_CONFIG1, d, 1'b0);
    chk("config1", 8'h03, d);
    i_host.rd_reg(8'h0c, d, 1'b0);
    chk("unmapped", 8'h00, d);
    $display("reset test done");
    repeat (4) begin
      en = 8'($urandom);
      i_host.wr_reg(ADDR_ENABLES, en);
      i_host.rd_reg(ADDR_ENABLES, d, 1'b0);
      chk("enables", en & 8'h7f, d);
      en = 8'($urandom) & 8'hcf;
      i_host.wr_reg(ADDR_CONFIG1, en);
      i_host.rd_reg(ADDR_CONFIG1, d, 1'b0);
      chk("config1", en & 8'h3b, d);
      chk("osc_on", {7'h0, en[0]}, {7'h0, osc_on});
    end
    i_host.wr_reg(ADDR_CONFIG1, 8'h03);
    $display("register test done");
    for (int s = 0; s < 2; s++) begin
      i_host.wr_reg(ADDR_CONFIG2, {5'h0, s[0], 2'h3});
      @(negedge clk);
      chk("clk_sel", {7'h0, s[0]}, {7'h0, cs});
      for (int i = 0; i < 12; i++) begin
        en = (i == 0) ? 8'h37 : (i == 1) ? 8'h00 : 8'($urandom) & 8'h37;
        f = (i < 2) ? 6'h37 : 6'($urandom);
        f[3] = 1'b0;
        i_host.wr_reg(ADDR_ENABLES, en);
        fire(f);
        chk("pins", pins(f & en[5:0], s[0]), {6'h0, pb_b, pa_b});
        rdf({2'h0, f & en[5:0]});
        rdf(8'h00);
        chk("pins", 8'h03, {6'h0, pb_b, pa_b});
      end
    end
    $display("flag test done");
    ev.source_on_backup = 1'b1;
    ev.osc_stopped = 1'b1;
    i_host.wr_reg(ADDR_ENABLES, 8'h00);
    rdf(8'hc0);
    rdf(8'hc0);
    i_host.wr_reg(ADDR_ENABLES, 8'h40);
    rdf(8'h80);
    ev.osc_stopped = 1'b0;
    ev.source_on_backup = 1'b0;
    i_host.wr_reg(ADDR_ENABLES, 8'h08);
    for (int p = 0; p < 2; p++) begin
      i_host.wr_reg(ADDR_CONFIG1, {4'h0, p[0], 3'h3});
      ev.din = !p[0];
      rdf(8'h00);
      rdf(8'h00);
      ev.din = p[0];
      rdf(8'h08);
      ev.din = !p[0];
      rdf(8'h00);
    end
    $display("input test done");
    i_host.wr_reg(ADDR_ENABLES, 8'h01);
    i_host.wr_reg(ADDR_CONFIG1, 8'h13);
    fire(6'h01);
    repeat (500) @(negedge clk);
    chk("pins", 8'h02, {6'h0, pb_b, pa_b});
    i_host.rd_reg(ADDR_FLAGS, d, 1'b0);
    chk("flags", 8'h01, d);
    rdf(8'h01);
    rdf(8'h00);
    chk("pins", 8'h03, {6'h0, pb_b, pa_b});
    $display("auto-clear test done");
    i_host.wr_reg(ADDR_ENABLES, 8'h7f);
    i_host.wr_reg(ADDR_RESET, 8'h01);
    chk("pulse", 8'h01, {7'h0, pulse});
    repeat (4) @(negedge clk);
    i_host.rd_reg(ADDR_ENABLES, d, 1'b0);
    chk("enables", 8'h00, d);
    i_host.rd_reg(ADDR_CONFIG1, d, 1'b0);
    chk("config1", 8'h02, d);
    i_host.rd_reg(ADDR_RESET, d, 1'b0);
    chk("reset", 8'h00, d);
    chk("osc_on", 8'h00, {7'h0, osc_on});
    $display("soft reset test done");
    complete_run();
  end
endmodule : rif_top_tb
`default_nettype wire
